/* hw/bbx_pkg.sv */
package bbx_pkg;
	localparam int          PC_W         = 21;
	localparam int          ADDR_W       = 12;
	localparam logic [4:0]  OPC_JUMP     = 5'h1a;
	localparam logic [3:0]  OPC_BSET     = 4'h8;
	localparam logic [3:0]  OPC_SKIP_CLR = 4'hb;
	localparam logic [3:0]  OPC_SKIP_SET = 4'ha;
	localparam logic [7:0]  OPC_JNZ      = 8'he1;
	localparam logic [7:0]  ILO_LIMIT    = 8'h5f;
	localparam logic [7:0]  ACC_LOW_TOP  = 8'h5f;
	localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
	localparam logic [1:0]  Q_READ       = 2'h1;
	localparam logic [1:0]  Q_WRITE      = 2'h3;
	localparam logic [1:0]  Q_LAST       = 2'h3;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} bbx_dwr_s;

	typedef struct packed {
		logic            load;
		logic [PC_W-1:0] value;
	} bbx_pcld_s;
endpackage : bbx_pkg

/* hw/bbx_exec.sv */
`timescale 1ns/10ps
module bbx_exec
	import bbx_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// fetch pipeline
	input  wire logic                 instr_valid,
	input  wire logic [15:0]          instr_word,
	input  wire logic                 next_is_two_word,
	input  wire logic [PC_W-1:0]      pc_now,
	// core state
	input  wire logic [3:0]           bank_pointer_register,
	input  wire logic [7:0]           index_base,
	input  wire logic                 ext_set_en,
	input  wire logic                 zero_flag,
	// data memory
	input  wire logic [7:0]           data_rdata,
	output bbx_pkg::bbx_dwr_s         data_req,
	output logic                      data_rd,
	// program counter and pipeline
	output bbx_pkg::bbx_pcld_s        pc_load,
	output logic                      flush_fetch,
	output logic                      busy,
	output logic [1:0]                q_phase
);
	import bbx_pkg::*;

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_IDLE = 3'b010,
		ST_IDL2 = 3'b100
	} bbx_state_e;

	bbx_state_e        state;
	logic [15:0]       ir;
	logic [ADDR_W-1:0] eff_addr;
	logic              is_jump, is_bset, is_sclr, is_sset, is_jnz;
	logic [2:0]        bit_idx;
	logic              tested;

	function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
			input logic [10:0] n);
		logic [PC_W-1:0] ext;
		ext = {{(PC_W-11){n[10]}}, n};
		rel_target = pc + 21'h2 + {ext[PC_W-2:0], 1'b0};
	endfunction : rel_target

	// instruction is latched only at Q-cycle start, held through the four quarters
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q_phase <= 2'h0;
		end else begin
			q_phase <= q_phase + 2'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ir <= 16'h0000;
		end else if (q_phase == Q_LAST) begin
			ir <= instr_valid ? instr_word : 16'h0000;
		end
	end

	assign is_jump = ir[15:11] == OPC_JUMP;
	assign is_bset = ir[15:12] == OPC_BSET;
	assign is_sclr = ir[15:12] == OPC_SKIP_CLR;
	assign is_sset = ir[15:12] == OPC_SKIP_SET;
	assign is_jnz  = ir[15:8] == OPC_JNZ;
	assign bit_idx = ir[11:9];
	assign tested  = data_rdata[bit_idx];

	// address resolution
	always_comb begin
		if (ir[8]) begin
			eff_addr = {bank_pointer_register, ir[7:0]};
		end else if (ext_set_en && ir[7:0] <= ILO_LIMIT) begin
			eff_addr = {4'h0, index_base} + {4'h0, ir[7:0]};
		end else if (ir[7:0] <= ACC_LOW_TOP) begin
			eff_addr = {4'h0, ir[7:0]};
		end else begin
			eff_addr = {ACC_HI_BANK, ir[7:0]};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_RUN;
			busy  <= 1'b0;
		end else if (q_phase == Q_LAST) begin
			unique case (state)
				ST_RUN: begin
					if (is_jump || (is_jnz && !zero_flag)) begin
						state <= ST_IDLE;
						busy  <= 1'b1;
					end else if ((is_sclr && !tested) || (is_sset && tested)) begin
						state <= next_is_two_word ? ST_IDL2 : ST_IDLE;
						busy  <= 1'b1;
					end
				end
				ST_IDL2: state <= ST_IDLE;
				ST_IDLE: begin
					state <= ST_RUN;
					busy  <= 1'b0;
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	// read in Q2 for bit set and bit tests, write in Q4 for bit set only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_rd  <= 1'b0;
			data_req <= '0;
		end else begin
			data_rd     <= 1'b0;
			data_req.we <= 1'b0;
			if (state == ST_RUN && (is_bset || is_sclr || is_sset)) begin
				if (q_phase == Q_READ - 2'h1) begin
					data_rd       <= 1'b1;
					data_req.addr <= eff_addr;
				end
				if (is_bset && q_phase == Q_WRITE - 2'h1) begin
					data_req.we    <= 1'b1;
					data_req.wdata <= data_rdata | (8'h01 << bit_idx);
				end
			end
		end
	end

	// pc redirect and fetch flush at end of the instruction's cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_load     <= '0;
			flush_fetch <= 1'b0;
		end else begin
			pc_load.load <= 1'b0;
			flush_fetch  <= 1'b0;
			if (state == ST_RUN && q_phase == Q_LAST) begin
				if (is_jump) begin
					pc_load.load  <= 1'b1;
					pc_load.value <= rel_target(pc_now, ir[10:0]);
					flush_fetch   <= 1'b1;
				end else if (is_jnz && !zero_flag) begin
					pc_load.load  <= 1'b1;
					pc_load.value <= rel_target(pc_now, {{3{ir[7]}}, ir[7:0]});
					flush_fetch   <= 1'b1;
				end else if ((is_sclr && !tested) || (is_sset && tested)) begin
					flush_fetch <= 1'b1;
				end
			end
		end
	end

	a_jump_redirect: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && is_jump) |=> pc_load.load && flush_fetch)
		else $error("jump did not redirect pc");
	a_jump_idle: assert property (@(posedge clk) disable iff (sys_rst)
		pc_load.load |-> busy[*4])
		else $error("jump second cycle not idle");
	a_bset_write: assert property (@(posedge clk) disable iff (sys_rst)
		data_req.we |-> data_req.wdata[bit_idx])
		else $error("bit set did not set the bit");
	a_bank_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(ir[8] && data_rd) |-> data_req.addr[ADDR_W-1:8] == $past(bank_pointer_register))
		else $error("banked address wrong");
	a_skip_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && is_sclr && !tested) |=> flush_fetch)
		else $error("skip if clear missed");
	a_skip_set: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && is_sset && tested) |=> flush_fetch)
		else $error("skip if set missed");
	a_skip_long: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_IDL2 && q_phase == Q_LAST) |=> state == ST_IDLE)
		else $error("two word skip wrong length");
	a_jnz_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && is_jnz && zero_flag) |=> !pc_load.load)
		else $error("jump taken with zero set");
	a_bset_phase: assert property (@(posedge clk) disable iff (sys_rst)
		data_req.we |-> q_phase == Q_LAST)
		else $error("write outside fourth quarter");
	a_bset_keep: assert property (@(posedge clk) disable iff (sys_rst)
		data_req.we |-> ((data_req.wdata ^ data_rdata) & ~(8'h01 << bit_idx)) == 8'h00)
		else $error("bit set changed other bits");
	a_access_low: assert property (@(posedge clk) disable iff (sys_rst)
		(data_rd && !ir[8] && !$past(ext_set_en) && ir[7:0] <= ACC_LOW_TOP)
		|-> data_req.addr == {4'h0, ir[7:0]})
		else $error("low access bank address wrong");
	a_access_high: assert property (@(posedge clk) disable iff (sys_rst)
		(data_rd && !ir[8] && ir[7:0] > ACC_LOW_TOP)
		|-> data_req.addr == {ACC_HI_BANK, ir[7:0]})
		else $error("high access bank address wrong");
	a_indexed_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(data_rd && !ir[8] && $past(ext_set_en) && ir[7:0] <= ILO_LIMIT)
		|-> data_req.addr == {4'h0, $past(index_base)} + {4'h0, ir[7:0]})
		else $error("indexed literal offset address wrong");
	a_skip_short: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && !next_is_two_word
			&& ((is_sclr && !tested) || (is_sset && tested))) |=> state == ST_IDLE && busy)
		else $error("one word skip wrong length");
	a_noskip_run: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && ((is_sclr && tested) || (is_sset && !tested)))
		|=> state == ST_RUN && !busy && !flush_fetch)
		else $error("untaken skip took extra cycles");
	a_jnz_taken: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && q_phase == Q_LAST && is_jnz && !zero_flag)
		|=> pc_load.load && flush_fetch)
		else $error("jump if nonzero not taken");
	a_read_phase: assert property (@(posedge clk) disable iff (sys_rst)
		data_rd |-> q_phase == Q_READ)
		else $error("read outside second quarter");
endmodule : bbx_exec

/* testbench/bbx_dmem_model.sv */
`timescale 1ns/10ps
module bbx_dmem_model
	import bbx_pkg::*;
(
	// core side
	input  wire logic               clk,
	input  wire logic [1:0]         q_phase,
	input  wire bbx_pkg::bbx_dwr_s  data_req,
	// read data
	output logic [7:0]              data_rdata
);
	logic [7:0] mem [4096];
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7);
	always @(posedge clk) if (data_req.we) mem[data_req.addr] <= data_req.wdata;
	// in the first quarter (q_phase 0) the bus is not held, so show the inverse
	assign data_rdata = (q_phase != 2'h0) ? mem[data_req.addr] : ~mem[data_req.addr];
endmodule : bbx_dmem_model

/* testbench/branch_bit_instr_exec_tb_top.sv */
`timescale 1ns/10ps
module branch_bit_instr_exec_tb_top;
	import bbx_pkg::*;
	logic            clk, sys_rst, instr_valid, next_is_two_word, ext_set_en, zero_flag;
	logic [15:0]     instr_word;
	logic [PC_W-1:0] pc_now;
	logic [3:0]      bank_pointer_register;
	logic [7:0]      index_base, data_rdata;
	bbx_dwr_s        data_req;
	bbx_pcld_s       pc_load;
	logic            data_rd, flush_fetch, busy;
	logic [1:0]      q_phase;
	logic [7:0]      ref_mem [4096];
	int              bad_count, checks;
	bbx_exec i_bbx_exec (.*);
	bbx_dmem_model i_bbx_dmem_model (.*);
	task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	function automatic logic [11:0] eff(logic [8:0] af);
		if (af[8]) return {bank_pointer_register, af[7:0]};
		if (ext_set_en && af[7:0] <= 8'h5f) return 12'(index_base) + 12'(af[7:0]);
		return {(af[7:0] > 8'h5f) ? 4'hf : 4'h0, af[7:0]};
	endfunction : eff
	task automatic run(logic [15:0] w);
		logic [11:0] a;
		logic        bt, skip, isbit, jmp, bset;
		logic [20:0] tgt;
		int          n;
		n = 0;
		while (!(q_phase == 2'h3 && !busy) && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		a = eff(w[8:0]);
		bt = ref_mem[a][w[11:9]];
		bset = w[15:12] == OPC_BSET;
		isbit = w[15:12] inside {OPC_BSET, OPC_SKIP_CLR, OPC_SKIP_SET};
		skip = (w[15:12] == OPC_SKIP_CLR && !bt) || (w[15:12] == OPC_SKIP_SET && bt);
		jmp = w[15:11] == OPC_JUMP || (w[15:8] == OPC_JNZ && !zero_flag);
		tgt = pc_now + 21'h2 + ((w[15:11] == OPC_JUMP) ? {{9{w[10]}}, w[10:0], 1'b0}
			: {{12{w[7]}}, w[7:0], 1'b0});
		instr_word = w;
		instr_valid = 1'b1;
		for (int k = 1; k <= 5; k++) begin
			@(posedge clk);
			#1;
			instr_word = 16'h0;
			instr_valid = 1'b0;
			chk("phase", 21'((k - 1) % 4), 21'(q_phase));
			if (k == 2) chk("rd", 21'(isbit), 21'(data_rd));
			if (k == 2 && isbit) chk("addr", 21'(a), 21'(data_req.addr));
			if (k == 4) chk("we", 21'(bset), 21'(data_req.we));
			if (k == 4 && bset) chk("wdata", 21'(ref_mem[a] | (8'h1 << w[11:9])), 21'(data_req.wdata));
			if (k == 5) chk("load", 21'(jmp), 21'(pc_load.load));
			if (k == 5 && jmp) chk("target", tgt, pc_load.value);
			if (k == 5) chk("flush", 21'(jmp || skip), 21'(flush_fetch));
		end
		n = 0;
		while (busy && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("idle", 21'((jmp ? 4 : 0) + (skip ? (next_is_two_word ? 8 : 4) : 0)), 21'(n));
		if (bset) ref_mem[a][w[11:9]] = 1'b1;
	endtask : run
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#400000;
		bad_count++;
		conclude();
	end
	initial begin
		logic [15:0] base [5];
		logic [15:0] mask [5];
		base = '{16'h8000, 16'hb000, 16'ha000, 16'hd000, 16'he100};
		mask = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h07ff, 16'h00ff};
		{sys_rst, instr_valid, next_is_two_word, ext_set_en, zero_flag} = 5'h10;
		instr_word = 16'h0;
		pc_now = '0;
		bank_pointer_register = '0;
		index_base = '0;
		for (int i = 0; i < 4096; i++) ref_mem[i] = 8'(i * 7);
		void'($urandom(5));
		repeat (4) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		run(16'hd400);
		run(16'hd3ff);
		for (int t = 0; t < 150; t++) begin
			{bank_pointer_register, index_base, ext_set_en, zero_flag, next_is_two_word} = 15'($urandom);
			pc_now = 21'($urandom) & ~21'h1;
			run(base[t % 5] | (16'($urandom) & mask[t % 5]));
		end
		conclude();
	end
endmodule : branch_bit_instr_exec_tb_top
